// [cfg_loader_consts.svh]
// Purpose: Named constants of the configuration loader
// Assumes: Included by the package and by every loader module
// Notes: Definitions only
`ifndef CFG_LOADER_CONSTS_SVH
`define CFG_LOADER_CONSTS_SVH

// Timing
`define CLK_PERIOD_NS 100
`define WAKE_WAIT_NS 30000
`define WAKE_WAIT_CYCLES ((`WAKE_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Flash command layout
`define CMD_W 40
`define OPCODE_BITS 6'h08
`define CMD_BITS 6'h28
`define FLASH_START_ADDR 24'h000000
`define DUMMY_BYTE 8'h00
`define WAKE_TAIL 32'h00000000

// Strap encodings
`define MODE_STRAP_ACTIVE 2'h0
`define MODE_STRAP_PASSIVE 2'h1
`define MODE_STRAP_JTAG 2'h2
`define WIDTH_X1 2'h0
`define WIDTH_X2 2'h1
`define WIDTH_X4 2'h2
`define WIDTH_X8 2'h3

// Byte assembly
`define BYTE_FILL 4'h8
`define RAM_ADDR_W 16

`endif

// [cfg_loader_pkg.sv]
// Purpose: Types shared by the configuration loader modules
// Assumes: cfg_loader_consts.svh gives the widths
// Notes: Types only
`include "cfg_loader_consts.svh"
package cfg_loader_pkg;

typedef logic [1:0] width_t;

typedef enum logic [1:0] {MODE_ACTIVE, MODE_PASSIVE, MODE_JTAG} mode_e;

typedef enum logic [3:0] {
	S_IDLE, S_WAKE, S_GAP, S_CMD, S_DATA, S_PASSIVE, S_JTAG, S_DONE, S_ERROR
} state_e;

typedef struct packed {
	logic en;
	logic [`RAM_ADDR_W-1:0] addr;
	logic [7:0] data;
} ram_wr_s;

typedef struct packed {
	logic cr;
	logic [1:0] mode;
	logic [1:0] width;
	logic [3:0] dq;
	logic pclk;
	logic pcs_n;
	logic [7:0] pdata;
	logic tck;
	logic tms;
	logic tdi;
} pin_s;

endpackage : cfg_loader_pkg

// [byte_collector.sv]
// Purpose: Gathers 1, 2, 4 or 8 lanes per strobe into bytes
// Assumes: Strobe is a one-cycle pulse on the loader clock
// Notes: First sample lands in the byte's most significant bits
`timescale 1ns/100ps
`include "cfg_loader_consts.svh"
module byte_collector
	import cfg_loader_pkg::*;
#(
	parameter int LANES = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic strobe,
	input wire width_t width,
	input wire logic [LANES-1:0] lanes,
	output logic [7:0] byte_data,
	output logic byte_valid
);

if (LANES != 8) begin : g_bad_lanes
	$error("byte_collector serves exactly eight lanes");
end

logic [7:0] shreg;
logic [3:0] fill;
logic [7:0] next_shreg;
logic [3:0] next_fill;

always_comb begin
	next_shreg = shreg;
	next_fill = fill;
	if (strobe) begin
		case (width)
			`WIDTH_X1: begin
				next_shreg = {shreg[6:0], lanes[0]};
				next_fill = fill + 4'h1;
			end
			`WIDTH_X2: begin
				next_shreg = {shreg[5:0], lanes[1:0]};
				next_fill = fill + 4'h2;
			end
			`WIDTH_X4: begin
				next_shreg = {shreg[3:0], lanes[3:0]};
				next_fill = fill + 4'h4;
			end
			default: begin
				next_shreg = lanes[7:0];
				next_fill = fill + 4'h8;
			end
		endcase
	end
end

always_ff @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		shreg <= 8'h00;
		fill <= 4'h0;
		byte_data <= 8'h00;
		byte_valid <= 1'b0;
	end else if (clear) begin
		shreg <= 8'h00;
		fill <= 4'h0;
		byte_valid <= 1'b0;
	end else begin
		shreg <= next_shreg;
		byte_valid <= 1'b0;
		if (next_fill >= `BYTE_FILL) begin
			byte_data <= next_shreg;
			byte_valid <= 1'b1;
			fill <= 4'h0;
		end else begin
			fill <= next_fill;
		end
	end
end

endmodule : byte_collector

// [fpga_config_loader.sv]
// Purpose: Loads the configuration bitstream into configuration RAM
// Assumes: 10 MHz clock; all pin inputs asynchronous to it
// Notes: Active mode drives the flash clock from a divider of clock
`timescale 1ns/100ps
`include "cfg_loader_consts.svh"
module fpga_config_loader
	import cfg_loader_pkg::*;
#(
	parameter int CONFIG_BYTES = 1024,
	parameter int SCK_HALF = 4,
	parameter logic [7:0] WAKE_OPCODE = 8'hab,
	parameter logic [7:0] READ_OPCODE = 8'h0b
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic config_reset_n,
	input wire logic [1:0] mode_strap,
	input wire logic [1:0] width_strap,
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_dq0_out,
	output logic spi_dq0_oe,
	input wire logic [3:0] spi_dq_in,
	input wire logic pass_clk,
	input wire logic pass_cs_n,
	input wire logic [7:0] pass_data,
	input wire logic jtag_tck,
	input wire logic jtag_tms,
	input wire logic jtag_tdi,
	output ram_wr_s config_ram,
	output logic config_done,
	output logic gpio_weak_pullup,
	output logic config_error
);

localparam int SW = $clog2(SCK_HALF) + 1;
localparam int BW = $clog2(CONFIG_BYTES + 1);

if (CONFIG_BYTES < 1 || CONFIG_BYTES > 65536) begin : g_bad_bytes
	$error("CONFIG_BYTES must lie in 1..65536");
end
if (SCK_HALF < 4) begin : g_bad_half
	$error("SCK_HALF below 4 leaves no room for the input synchroniser");
end

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: stage a feeds stage b only
pin_s pins;
pin_s sync_a;
pin_s sync_b;
pin_s sync_d;

assign pins = '{cr: config_reset_n, mode: mode_strap, width: width_strap, dq: spi_dq_in,
	pclk: pass_clk, pcs_n: pass_cs_n, pdata: pass_data, tck: jtag_tck, tms: jtag_tms,
	tdi: jtag_tdi};

always_ff @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		sync_a <= '0;
		sync_b <= '0;
		sync_d <= '0;
	end else begin
		sync_a <= pins;
		sync_b <= sync_a;
		sync_d <= sync_b;
	end
end

logic cr_rise;
logic cr_fall;
logic pass_rise;
logic tck_rise;
assign cr_rise = sync_b.cr & ~sync_d.cr;
assign cr_fall = ~sync_b.cr & sync_d.cr;
assign pass_rise = sync_b.pclk & ~sync_d.pclk & ~sync_b.pcs_n;
assign tck_rise = sync_b.tck & ~sync_d.tck & ~sync_b.tms;

////////////////////////////////////////////////////////////////////////////////
// Flash clock divider
state_e state;
width_t width;
logic [SW-1:0] sck_cnt;
logic running;
logic sck_last;
logic hi_end;
logic lo_end;

assign running = (state == S_WAKE) || (state == S_CMD) || (state == S_DATA);
assign sck_last = sck_cnt == SW'(SCK_HALF - 1);
assign hi_end = running & spi_clk & sck_last;
assign lo_end = running & ~spi_clk & sck_last;

always_ff @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		spi_clk <= 1'b0;
		sck_cnt <= '0;
	end else if (!running) begin
		spi_clk <= 1'b0;
		sck_cnt <= '0;
	end else if (sck_last) begin
		sck_cnt <= '0;
		spi_clk <= ~spi_clk;
	end else begin
		sck_cnt <= sck_cnt + SW'(1);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer
logic [`CMD_W-1:0] cmd_sh;
logic [5:0] bit_cnt;
logic [15:0] gap_cnt;
logic wake_sent;
logic loaded;
logic start;

assign start = (state == S_IDLE) & cr_rise;
assign spi_dq0_out = cmd_sh[`CMD_W-1];

always_ff @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		state <= S_IDLE;
		width <= `WIDTH_X1;
		cmd_sh <= '0;
		bit_cnt <= 6'h00;
		gap_cnt <= 16'h0000;
		spi_cs_n <= 1'b1;
		spi_dq0_oe <= 1'b0;
		wake_sent <= 1'b0;
		config_error <= 1'b0;
	end else if (cr_fall) begin
		// Pulling config_reset_n low aborts and rearms any load
		state <= S_IDLE;
		spi_cs_n <= 1'b1;
		spi_dq0_oe <= 1'b0;
		wake_sent <= 1'b0;
		config_error <= 1'b0;
	end else begin
		case (state)
			S_IDLE: begin
				if (start) begin
					case (sync_b.mode)
						`MODE_STRAP_ACTIVE: begin
							if (sync_b.width == `WIDTH_X8) begin
								state <= S_ERROR;
								config_error <= 1'b1;
							end else begin
								width <= sync_b.width;
								state <= S_WAKE;
								spi_cs_n <= 1'b0;
								spi_dq0_oe <= 1'b1;
								cmd_sh <= {WAKE_OPCODE, `WAKE_TAIL};
								bit_cnt <= 6'h00;
							end
						end
						`MODE_STRAP_PASSIVE: begin
							width <= sync_b.width;
							state <= S_PASSIVE;
						end
						`MODE_STRAP_JTAG: begin
							width <= `WIDTH_X1;
							state <= S_JTAG;
						end
						default: begin
							state <= S_ERROR;
							config_error <= 1'b1;
						end
					endcase
				end
			end
			S_WAKE: begin
				if (lo_end) begin
					bit_cnt <= bit_cnt + 6'h01;
				end
				if (hi_end) begin
					if (bit_cnt == `OPCODE_BITS) begin
						state <= S_GAP;
						spi_cs_n <= 1'b1;
						spi_dq0_oe <= 1'b0;
						gap_cnt <= 16'h0000;
						wake_sent <= 1'b1;
					end else begin
						cmd_sh <= {cmd_sh[`CMD_W-2:0], 1'b0};
					end
				end
			end
			S_GAP: begin
				gap_cnt <= gap_cnt + 16'h0001;
				if (gap_cnt == 16'(`WAKE_WAIT_CYCLES - 1)) begin
					state <= S_CMD;
					spi_cs_n <= 1'b0;
					spi_dq0_oe <= 1'b1;
					cmd_sh <= {READ_OPCODE, `FLASH_START_ADDR, `DUMMY_BYTE};
					bit_cnt <= 6'h00;
				end
			end
			S_CMD: begin
				if (lo_end) begin
					bit_cnt <= bit_cnt + 6'h01;
				end
				if (hi_end) begin
					if (bit_cnt == `CMD_BITS) begin
						state <= S_DATA;
						spi_dq0_oe <= 1'b0;
					end else begin
						cmd_sh <= {cmd_sh[`CMD_W-2:0], 1'b0};
					end
				end
			end
			S_DATA: begin
				// One open read streams the whole image
				if (loaded) begin
					state <= S_DONE;
					spi_cs_n <= 1'b1;
				end
			end
			S_PASSIVE, S_JTAG: begin
				if (loaded) begin
					state <= S_DONE;
				end
			end
			S_DONE, S_ERROR: begin
				state <= state;
			end
			default: begin
				state <= S_IDLE;
			end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Lane selection and byte assembly
logic strobe;
logic [7:0] lanes;
logic [7:0] byte_data;
logic byte_valid;
logic [BW-1:0] byte_count;

always_comb begin
	strobe = 1'b0;
	lanes = 8'h00;
	case (state)
		S_DATA: begin
			// Sample at the end of the high half, well after the synchroniser settles
			strobe = hi_end;
			case (width)
				`WIDTH_X1: lanes = {7'h00, sync_b.dq[1]};
				`WIDTH_X2: lanes = {6'h00, sync_b.dq[1:0]};
				default: lanes = {4'h0, sync_b.dq};
			endcase
		end
		S_PASSIVE: begin
			strobe = pass_rise;
			lanes = sync_b.pdata;
		end
		S_JTAG: begin
			strobe = tck_rise;
			lanes = {7'h00, sync_b.tdi};
		end
		default: begin
			strobe = 1'b0;
		end
	endcase
end

byte_collector #(
	.LANES(8)
) u_collector (
	.clock(clock),
	.rst_n(rst_n),
	.clear(start),
	.strobe(strobe),
	.width(width),
	.lanes(lanes),
	.byte_data(byte_data),
	.byte_valid(byte_valid)
);

assign loaded = byte_count == BW'(CONFIG_BYTES);

always_ff @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		byte_count <= '0;
		config_ram <= '0;
	end else if (start) begin
		byte_count <= '0;
		config_ram.en <= 1'b0;
	end else if (byte_valid && !loaded && (state == S_DATA || state == S_PASSIVE ||
		state == S_JTAG)) begin
		config_ram <= '{en: 1'b1, addr: `RAM_ADDR_W'(byte_count), data: byte_data};
		byte_count <= byte_count + BW'(1);
	end else begin
		config_ram.en <= 1'b0;
	end
end

always_ff @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		config_done <= 1'b0;
		gpio_weak_pullup <= 1'b1;
	end else if (cr_fall) begin
		config_done <= 1'b0;
		gpio_weak_pullup <= 1'b1;
	end else if (state == S_DONE) begin
		config_done <= 1'b1;
		gpio_weak_pullup <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Checks
logic [15:0] cs_high_cnt;

always_ff @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		cs_high_cnt <= 16'h0000;
	end else if (!spi_cs_n) begin
		cs_high_cnt <= 16'h0000;
	end else if (cs_high_cnt != 16'hffff) begin
		cs_high_cnt <= cs_high_cnt + 16'h0001;
	end
end

default clocking cb @(posedge clock); endclocking
default disable iff (!rst_n);

sequence s_enter_read;
	state == S_GAP ##1 state == S_CMD;
endsequence

sequence s_wake_end;
	state == S_WAKE ##1 state == S_GAP;
endsequence

AST_DONE_AFTER_LOAD: assert property ($rose(config_done) |-> $past(loaded) && loaded)
	else $error("config_done rose before the image was loaded");
AST_NO_WRITE_WHEN_DONE: assert property (config_done |-> !config_ram.en)
	else $error("configuration RAM written after done");
AST_SCK_HALF: assert property ($changed(spi_clk) && running |=> (!running || $stable(spi_clk))[*3])
	else $error("flash clock half period too short");
AST_WAKE_LEN: assert property (s_wake_end |-> spi_cs_n && $past(bit_cnt) == `OPCODE_BITS)
	else $error("wake transaction not eight bits");
AST_WAKE_FIRST: assert property ($rose(state == S_CMD) |-> wake_sent)
	else $error("read issued before wake instruction");
AST_WAKE_GAP: assert property (wake_sent && $fell(spi_cs_n) |-> cs_high_cnt >= `WAKE_WAIT_CYCLES)
	else $error("read started before the wake wait elapsed");
AST_READ_CMD: assert property (s_enter_read |-> !spi_cs_n && spi_dq0_oe &&
	cmd_sh == {READ_OPCODE, `FLASH_START_ADDR, `DUMMY_BYTE})
	else $error("fast read command or address wrong");
AST_ACTIVE_WIDTH: assert property (state == S_DATA |-> width != `WIDTH_X8)
	else $error("active mode running at width X8");
AST_JTAG_X1: assert property (state == S_JTAG |-> width == `WIDTH_X1 && spi_cs_n)
	else $error("JTAG load not at width X1 or flash selected");
AST_PULLUP: assert property (!config_done |-> gpio_weak_pullup)
	else $error("pull-up released while configuring");

endmodule : fpga_config_loader

// [flash_model.sv]
// Purpose: Behavioural serial flash on the far side of the active link
// Assumes: Width follows the same strap as the loader
// Notes: Image byte n is 8'h3c plus n times 8'h1d
`timescale 1ns/100ps
module flash_model (
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_dq0,
	input wire logic rearm_n,
	input wire logic [1:0] width,
	output logic [3:0] dq
);
	logic [7:0] wake;
	logic [39:0] cmd;
	logic [7:0] b;
	int nsel = 0;
	int nbits = 0;
	int pos = 0;
	int w;
	realtime t_rise = 0;
	realtime gap_ns = 0;

	initial dq = 4'h0;
	always @(negedge rearm_n) nsel = 0;
	always @(negedge spi_cs_n) begin
		nsel++;
		nbits = 0;
		pos = 0;
		if (nsel == 2)
			gap_ns = $realtime - t_rise;
	end
	// A released line shows the inverse of its last level, never a held value
	always @(posedge spi_cs_n) begin
		t_rise = $realtime;
		dq = ~dq;
	end
	always @(posedge spi_clk) if (!spi_cs_n) begin
		if (nsel == 1)
			wake = {wake[6:0], spi_dq0};
		else if (nbits < 40)
			cmd = {cmd[38:0], spi_dq0};
		nbits++;
	end
	// Data leaves on each fall once command and dummy bits are in
	always @(negedge spi_clk) if (!spi_cs_n && nsel == 2 && nbits >= 40) begin
		w = 1 << width;
		b = 8'h3c + 8'(pos / 8) * 8'h1d;
		b = b << (pos % 8);
		dq = (w == 1) ? {2'h0, b[7], 1'b0} : 4'(b >> (8 - w));
		pos += w;
	end
endmodule : flash_model

// [fpga_config_loader_test.sv]
// Purpose: Self-checking bench of the configuration loader
// Assumes: Flash model on the active link; bench drives passive and JTAG pins
// Notes: A short image keeps each load under 1100 cycles
`timescale 1ns/100ps
module fpga_config_loader_test;
	import cfg_loader_pkg::*;
	localparam int NB = 6;
	typedef struct {logic [1:0] m; logic [1:0] w; logic err;} row_s;
	logic clock, rst_n, config_reset_n, spi_clk, spi_cs_n, spi_dq0_out, spi_dq0_oe;
	logic pass_clk, pass_cs_n, jtag_tck, jtag_tms, jtag_tdi;
	logic config_done, gpio_weak_pullup, config_error;
	logic [1:0] mode_strap, width_strap;
	logic [3:0] spi_dq_in;
	logic [7:0] pass_data;
	ram_wr_s config_ram;
	int miscompares = 0;
	int checked = 0;
	int got = 0;
	row_s rows [10] = '{'{2'h0, 2'h0, 1'b0}, '{2'h0, 2'h1, 1'b0}, '{2'h0, 2'h2, 1'b0},
		'{2'h1, 2'h0, 1'b0}, '{2'h1, 2'h1, 1'b0}, '{2'h1, 2'h2, 1'b0}, '{2'h1, 2'h3, 1'b0},
		'{2'h2, 2'h3, 1'b0}, '{2'h0, 2'h3, 1'b1}, '{2'h3, 2'h0, 1'b1}};

	fpga_config_loader #(.CONFIG_BYTES(NB)) i_dut (.clock, .rst_n, .config_reset_n,
		.mode_strap, .width_strap, .spi_clk, .spi_cs_n, .spi_dq0_out, .spi_dq0_oe, .spi_dq_in,
		.pass_clk, .pass_cs_n, .pass_data, .jtag_tck, .jtag_tms, .jtag_tdi, .config_ram,
		.config_done, .gpio_weak_pullup, .config_error);
	flash_model i_flash (.spi_clk, .spi_cs_n, .spi_dq0(spi_dq0_out),
		.rearm_n(config_reset_n), .width(width_strap), .dq(spi_dq_in));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask : check

	task automatic finish_test();
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#10;
	endtask : tick

	task automatic wait_done();
		int i;
		for (i = 0; i < 4000 && config_done !== 1'b1; i++)
			tick(1);
		if (i == 4000) begin
			miscompares++;
			finish_test();
		end
	endtask : wait_done

	// One link clock of 800 ns carrying a chunk on data or tdi
	task automatic send(input logic jt, input logic [7:0] d);
		pass_data = d;
		jtag_tdi = d[0];
		tick(4);
		if (jt)
			jtag_tck = 1'b1;
		else
			pass_clk = 1'b1;
		tick(4);
		pass_clk = 1'b0;
		jtag_tck = 1'b0;
	endtask : send

	task automatic load(input row_s r);
		int w;
		logic [7:0] b;
		mode_strap = r.m;
		width_strap = r.w;
		config_reset_n = 1'b0;
		tick(5);
		check(config_error, 1'b0, "error kept after rearm");
		check(gpio_weak_pullup, 1'b1, "pull-up off when rearmed");
		got = 0;
		config_reset_n = 1'b1;
		tick(5);
		if (r.err) begin
			check(config_error, 1'b1, "illegal strap taken");
			check(spi_cs_n, 1'b1, "flash selected on bad strap");
			return;
		end
		check(config_done, 1'b0, "done before load");
		check(gpio_weak_pullup, 1'b1, "pull-up off in load");
		if (r.m != 2'h0) begin
			w = (r.m == 2'h2) ? 1 : 1 << r.w;
			pass_cs_n = 1'b0;
			jtag_tms = 1'b0;
			// One byte past the image end must be ignored
			for (int n = 0; n <= NB; n++) begin
				b = 8'h3c + 8'(n) * 8'h1d;
				for (int k = 0; k < 8 / w; k++)
					send(r.m == 2'h2, (b << (k * w)) >> (8 - w));
			end
			pass_cs_n = 1'b1;
			jtag_tms = 1'b1;
			pass_data = ~pass_data;
		end
		wait_done();
		check(got, NB, "byte count");
		check(gpio_weak_pullup, 1'b0, "pull-up after load");
		if (r.m == 2'h0) begin
			check(i_flash.wake, 8'hab, "wake opcode");
			check(i_flash.cmd, {8'h0b, 24'h000000, 8'h00}, "read command");
			check(i_flash.gap_ns >= 30000.0, 1'b1, "wake gap short");
			check({spi_cs_n, spi_clk, spi_dq0_oe}, 3'b100, "link not idle");
		end
	endtask : load

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clock) if (config_ram.en === 1'b1) begin
		check(config_ram.addr, got, "ram address");
		check(config_ram.data, 8'h3c + 8'(got) * 8'h1d, "ram data");
		got++;
	end

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	initial begin
		rst_n = 1'b0;
		config_reset_n = 1'b0;
		mode_strap = 2'h0;
		width_strap = 2'h0;
		pass_clk = 1'b0;
		pass_cs_n = 1'b1;
		pass_data = 8'h00;
		jtag_tck = 1'b0;
		jtag_tms = 1'b1;
		jtag_tdi = 1'b0;
		tick(20);
		check({spi_cs_n, spi_clk, spi_dq0_oe, config_done, gpio_weak_pullup, config_error,
			config_ram.en}, 7'b1000100, "reset values");
		rst_n = 1'b1;
		foreach (rows[i])
			load(rows[i]);
		// Abort inside the wake gap, then a full reload must still work
		// Straps back to active X1, or the last row would leave the loader in error
		config_reset_n = 1'b0;
		mode_strap = 2'h0;
		width_strap = 2'h0;
		tick(5);
		config_reset_n = 1'b1;
		tick(150);
		check(i_flash.nsel, 1, "wake not sent before abort");
		check(spi_cs_n, 1'b1, "read before gap ended");
		config_reset_n = 1'b0;
		tick(5);
		check({config_done, gpio_weak_pullup, spi_cs_n}, 3'b011, "abort");
		load(rows[2]);
		finish_test();
	end
endmodule : fpga_config_loader_test
